// ---- hw/status_xfer_pkg.sv ----
package status_xfer_pkg;
  localparam int FLAG_HI = 31;
  localparam int FLAG_LO = 28;
  localparam int IRQ_DIS_BIT = 7;
  localparam int FIQ_DIS_BIT = 6;
  localparam int MODE_HI = 4;
  localparam int COND_HI = 31;
  localparam int COND_LO = 28;
  localparam int SEL_BIT = 22;
  localparam int OPERAND_BIT = 25;
  localparam int RD_HI = 15;
  localparam int RD_LO = 12;
  localparam logic [31:0] READ_MASK = 32'h0fbf0fff;
  localparam logic [31:0] READ_CODE = 32'h010f0000;
  localparam logic [31:0] WHOLE_MASK = 32'h0fbffff0;
  localparam logic [31:0] WHOLE_CODE = 32'h0129f000;
  localparam logic [31:0] FLAGS_MASK = 32'h0dbff000;
  localparam logic [31:0] FLAGS_CODE = 32'h0128f000;
  localparam logic [31:0] FLAGS_REG_MASK = 32'h00000ff0;
  localparam logic [4:0] MODE_USER = 5'h10;
  localparam logic [4:0] MODE_FIQ = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_ABT = 5'h17;
  localparam logic [4:0] MODE_UND = 5'h1b;
  localparam int BANKS = 5;
  localparam logic [3:0] RESET_FLAGS = 4'h0;
  localparam logic RESET_IRQ_DIS = 1'b1;
  localparam logic RESET_FIQ_DIS = 1'b1;
  localparam logic [4:0] RESET_MODE = MODE_SVC;
  localparam logic [10:0] RESET_SAVED = 11'h000;

  // Stored layout {N,Z,C,V,I,F,M[4:0]}
  function automatic logic [10:0] compact(input logic [31:0] w);
    compact = {w[FLAG_HI:FLAG_LO], w[IRQ_DIS_BIT], w[FIQ_DIS_BIT], w[MODE_HI:0]};
  endfunction

  // Reserved positions 27:8 and 5 come back as zero
  function automatic logic [31:0] expand(input logic [10:0] s);
    expand = {s[10:7], 20'h00000, s[6], s[5], 1'b0, s[4:0]};
  endfunction
endpackage

// ---- hw/status_xfer_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface status_xfer_if;
  logic [3:0] cond;
  logic [3:0] flags;
  logic [11:0] imm_field;
  logic pass;
  logic [31:0] imm_word;
  modport user (output cond, output flags, output imm_field, input pass, input imm_word);
  modport unit (input cond, input flags, input imm_field, output pass, output imm_word);
endinterface
`default_nettype wire

// ---- hw/cond_imm_unit.sv ----
`timescale 1ns/100ps
`default_nettype none
module cond_imm_unit (
  status_xfer_if.unit port_if
);
  logic n;
  logic z;
  logic c;
  logic v;
  logic [63:0] doubled;
  logic [5:0] amount;

  assign n = port_if.flags[3];
  assign z = port_if.flags[2];
  assign c = port_if.flags[1];
  assign v = port_if.flags[0];

  // Condition evaluation against current flags
  always_comb begin
    case (port_if.cond)
      4'h0: port_if.pass = z;
      4'h1: port_if.pass = !z;
      4'h2: port_if.pass = c;
      4'h3: port_if.pass = !c;
      4'h4: port_if.pass = n;
      4'h5: port_if.pass = !n;
      4'h6: port_if.pass = v;
      4'h7: port_if.pass = !v;
      4'h8: port_if.pass = c && !z;
      4'h9: port_if.pass = !c || z;
      4'ha: port_if.pass = (n == v);
      4'hb: port_if.pass = (n != v);
      4'hc: port_if.pass = !z && (n == v);
      4'hd: port_if.pass = z || (n != v);
      4'he: port_if.pass = 1'b1;
      default: port_if.pass = 1'b0;
    endcase
  end

  // Zero-extend and rotate right by twice the rotate field
  assign amount = {1'b0, port_if.imm_field[11:8], 1'b0};
  assign doubled = {24'h000000, port_if.imm_field[7:0], 24'h000000, port_if.imm_field[7:0]} >> amount;
  assign port_if.imm_word = doubled[31:0];
endmodule
`default_nettype wire

// ---- hw/status_word_transfer_unit.sv ----
`timescale 1ns/100ps
`default_nettype none
module status_word_transfer_unit
  import status_xfer_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Instruction stream
  input wire logic instr_valid_in,
  input wire logic [31:0] instr_in,
  input wire logic [31:0] source_register_in,
  // Register file write-back
  output logic dest_write_out,
  output logic [3:0] dest_index_out,
  output logic [31:0] dest_data_out,
  output logic done_out,
  // Status view
  output logic [31:0] current_status_word_out,
  output logic [4:0] mode_out
);
  status_xfer_if xif ();

  // Instruction fields
  logic [3:0] cond_field;
  logic [3:0] dest_field;
  logic [11:0] operand_field;
  logic operand_is_imm;
  logic sel_saved;

  // Decode
  logic is_read;
  logic is_whole;
  logic is_flags;
  logic is_xfer;
  logic exec;
  logic read_act;
  logic write_op;
  logic cur_write;
  logic saved_write;
  logic whole_allowed;

  // Current status word
  logic [3:0] cur_flags;
  logic cur_irq_dis;
  logic cur_fiq_dis;
  logic [4:0] cur_mode;
  logic [10:0] cur_packed;
  logic [3:0] next_flags;
  logic next_irq_dis;
  logic next_fiq_dis;
  logic [4:0] next_mode;
  logic [10:0] next_packed;

  // Saved status words
  logic [10:0] saved_bank [0:BANKS-1];
  logic bank_ok;
  logic [2:0] bank_idx;
  logic [BANKS-1:0] bank_write;
  logic [10:0] saved_now;
  logic [10:0] next_saved;

  // Data paths
  logic [31:0] src_word;
  logic [31:0] read_word;

  cond_imm_unit u_cond_imm (
    .port_if(xif.unit)
  );

  // Field extraction
  assign cond_field = instr_in[COND_HI:COND_LO];
  assign dest_field = instr_in[RD_HI:RD_LO];
  assign operand_field = instr_in[11:0];
  assign operand_is_imm = instr_in[OPERAND_BIT];
  assign sel_saved = instr_in[SEL_BIT];

  // Condition and immediate unit hookup
  assign xif.cond = cond_field;
  assign xif.flags = cur_flags;
  assign xif.imm_field = operand_field;

  // Compare/test opcodes with the flag-set bit clear
  assign is_read = (instr_in & READ_MASK) == READ_CODE;
  assign is_whole = (instr_in & WHOLE_MASK) == WHOLE_CODE;
  assign is_flags = ((instr_in & FLAGS_MASK) == FLAGS_CODE) && !is_whole
    && (operand_is_imm || ((instr_in & FLAGS_REG_MASK) == 32'h00000000));
  assign is_xfer = is_read || is_whole || is_flags;

  // Only a passing condition lets a transfer act
  assign exec = instr_valid_in && xif.pass && is_xfer;
  assign read_act = exec && is_read;
  assign write_op = exec && (is_whole || is_flags);

  // Write steering
  assign cur_write = write_op && !sel_saved;
  assign saved_write = write_op && sel_saved && bank_ok;
  assign whole_allowed = is_whole && (cur_mode != MODE_USER);

  // Operand select for the flags-only form
  assign src_word = (is_flags && operand_is_imm) ? xif.imm_word : source_register_in;

  // Banked saved word picked by the mode in force
  always_comb begin
    bank_ok = 1'b1;
    case (cur_mode)
      MODE_FIQ: bank_idx = 3'h0;
      MODE_IRQ: bank_idx = 3'h1;
      MODE_SVC: bank_idx = 3'h2;
      MODE_ABT: bank_idx = 3'h3;
      MODE_UND: bank_idx = 3'h4;
      default: begin
        bank_idx = 3'h0;
        bank_ok = 1'b0;
      end
    endcase
  end

  // One-hot write enable for the bank in use
  always_comb begin
    bank_write = 5'h00;
    for (int i = 0; i < BANKS; i++) begin
      bank_write[i] = saved_write && (bank_idx == 3'(i));
    end
  end

  // Modes without a bank read back as zero
  assign saved_now = bank_ok ? saved_bank[bank_idx] : 11'h000;

  // Whole form replaces the word, flags form only the top four
  always_comb begin
    next_saved = saved_now;
    if (is_whole) begin
      next_saved = compact(src_word);
    end else begin
      next_saved[10:7] = src_word[FLAG_HI:FLAG_LO];
    end
  end

  // Saved status words, one per privileged mode
  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
        saved_bank[b] <= RESET_SAVED;
      end else if (bank_write[b]) begin
        saved_bank[b] <= next_saved;
      end
    end
  end

  // Next current word: flags always, control bits only when privileged
  always_comb begin
    next_flags = cur_flags;
    next_irq_dis = cur_irq_dis;
    next_fiq_dis = cur_fiq_dis;
    next_mode = cur_mode;
    if (cur_write) begin
      next_flags = src_word[FLAG_HI:FLAG_LO];
      if (whole_allowed) begin
        next_irq_dis = src_word[IRQ_DIS_BIT];
        next_fiq_dis = src_word[FIQ_DIS_BIT];
        next_mode = src_word[MODE_HI:0];
      end
    end
  end

  assign cur_packed = {cur_flags, cur_irq_dis, cur_fiq_dis, cur_mode};
  assign next_packed = {next_flags, next_irq_dis, next_fiq_dis, next_mode};

  // Current status word: only defined bits are held
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cur_flags <= RESET_FLAGS;
      cur_irq_dis <= RESET_IRQ_DIS;
      cur_fiq_dis <= RESET_FIQ_DIS;
      cur_mode <= RESET_MODE;
    end else begin
      cur_flags <= next_flags;
      cur_irq_dis <= next_irq_dis;
      cur_fiq_dis <= next_fiq_dis;
      cur_mode <= next_mode;
    end
  end

  // Status view register, reserved positions zero
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      current_status_word_out <= expand({RESET_FLAGS, RESET_IRQ_DIS, RESET_FIQ_DIS, RESET_MODE});
      mode_out <= RESET_MODE;
    end else begin
      current_status_word_out <= expand(next_packed);
      mode_out <= next_mode;
    end
  end

  // Read source: current word or the banked copy
  assign read_word = sel_saved ? expand(saved_now) : expand(cur_packed);

  // Read result lands one cycle after the fetch
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      dest_write_out <= 1'b0;
      dest_index_out <= 4'h0;
      dest_data_out <= 32'h00000000;
    end else begin
      dest_write_out <= read_act;
      if (read_act) begin
        dest_index_out <= dest_field;
        dest_data_out <= read_word;
      end
    end
  end

  // Every recognised transfer answers after one fetch
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= instr_valid_in && is_xfer;
    end
  end
endmodule
`default_nettype wire

// ---- sim/status_xfer_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module status_xfer_checker
  import status_xfer_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic instr_valid_in,
  input wire logic [31:0] instr_in,
  input wire logic [31:0] source_register_in,
  input wire logic dest_write_out,
  input wire logic [3:0] dest_index_out,
  input wire logic [31:0] dest_data_out,
  input wire logic done_out,
  input wire logic [31:0] current_status_word_out,
  input wire logic [4:0] mode_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic go, rd, wh, fr;
  logic [31:0] sw;
  assign sw = current_status_word_out;
  assign go = instr_valid_in && instr_in[31:28] == 4'he && !instr_in[SEL_BIT];
  assign rd = go && (instr_in & READ_MASK) == READ_CODE;
  assign wh = go && (instr_in & WHOLE_MASK) == WHOLE_CODE;
  assign fr = go && (instr_in & (FLAGS_MASK | FLAGS_REG_MASK | 32'h02000000)) == FLAGS_CODE;
  AST_RESERVED: assert property (sw[27:8] == 20'h0 && !sw[5])
    else $error("reserved bit set");
  AST_MODE: assert property (mode_out == sw[4:0])
    else $error("mode mismatch");
  AST_DONE: assert property (rd || wh || fr |=> done_out)
    else $error("no done");
  AST_NEVER: assert property (instr_valid_in && instr_in[31:28] == 4'hf |=> !dest_write_out && $stable(sw))
    else $error("failed condition acted");
  AST_READ: assert property (rd |=> dest_write_out &&
    dest_index_out == $past(instr_in[15:12]) && dest_data_out == $past(sw)) else $error("bad read");
  AST_USER: assert property (mode_out == MODE_USER |=> sw[7:0] == $past(sw[7:0]))
    else $error("user changed control");
  AST_FLAGS: assert property (fr |=> sw == {$past(source_register_in[31:28]), $past(sw[27:0])})
    else $error("bad flags write");
  AST_PRIV: assert property (wh && mode_out != MODE_USER |=> sw == ($past(source_register_in) & 32'hf00000df))
    else $error("bad whole write");
endmodule
`default_nettype wire

// ---- sim/status_word_transfer_unit_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module status_word_transfer_unit_test;
  import status_xfer_pkg::*;
  logic clk_in = 1'b0, resetn_in = 1'b0, valid = 1'b0, dw, done;
  logic [31:0] instr = 32'h0, src = 32'h0, dd, sw;
  logic [3:0] di;
  logic [4:0] mode;
  int n_errors = 0, total_checks = 0;
  status_word_transfer_unit uut (.clk_in(clk_in), .resetn_in(resetn_in), .instr_valid_in(valid),
    .instr_in(instr), .source_register_in(src), .dest_write_out(dw), .dest_index_out(di),
    .dest_data_out(dd), .done_out(done), .current_status_word_out(sw), .mode_out(mode));
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One instruction, outputs sampled after the answering edge
  task op(input logic [31:0] i, input logic [31:0] s);
    @(posedge clk_in);
    valid <= 1'b1;
    instr <= i;
    src <= s;
    @(posedge clk_in);
    valid <= 1'b0;
    #1;
  endtask
  task complete_run;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    #1;
    chk(sw, 32'h000000d3);
    op(32'he10f5000, 32'h0);
    chk({dw, di}, 32'h15);
    chk(dd, 32'h000000d3);
    $display("test read done");
    op(32'he328f20a, 32'h0);
    chk(sw, 32'ha00000d3);
    op(32'he128f000, 32'h5fffffff);
    chk(sw, 32'h500000d3);
    op(32'h1328f20a, 32'h0);
    chk(sw, 32'h500000d3);
    chk(done, 32'h1);
    op(32'hf128f000, 32'h0);
    chk(sw, 32'h500000d3);
    op(32'h0328f2ff, 32'h0);
    chk(sw, 32'hf00000d3);
    $display("test flags done");
    op(32'he169f001, 32'hffffffff);
    chk(sw, 32'hf00000d3);
    op(32'he14f2000, 32'h0);
    chk(dd, 32'hf00000df);
    op(32'he129f001, 32'h000000d1);
    chk(sw, 32'h000000d1);
    op(32'he14f2000, 32'h0);
    chk(dd, 32'h0);
    op(32'he10f1000, 32'h0);
    chk(dd, 32'h000000d1);
    op(32'he129f001, (dd & 32'hffffffe0) | 32'h00000010);
    chk(sw, 32'h000000d0);
    op(32'he129f001, 32'hf00000d3);
    chk(sw, 32'hf00000d0);
    op(32'he1300000, 32'h0);
    chk(done, 32'h0);
    $display("test modes done");
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    #1;
    chk(sw, 32'h000000d3);
    chk({dw, done}, 32'h0);
    op(32'he14f2000, 32'h0);
    chk({dw, di}, 32'h12);
    chk(dd, 32'h0);
    $display("test reset done");
    complete_run();
  end
endmodule
bind status_word_transfer_unit status_xfer_checker chk_i (.clk_in(clk_in), .resetn_in(resetn_in),
  .instr_valid_in(instr_valid_in), .instr_in(instr_in), .source_register_in(source_register_in),
  .dest_write_out(dest_write_out), .dest_index_out(dest_index_out), .dest_data_out(dest_data_out),
  .done_out(done_out), .current_status_word_out(current_status_word_out), .mode_out(mode_out));
`default_nettype wire
